// file: src/lsir_params.svh
// Constants of the link status, idle restart and serial cache block.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register port.
`ifndef LSIR_PARAMS_SVH
`define LSIR_PARAMS_SVH

`define LSIR_CLK_HZ          100000000
`define LSIR_SECOND_S        1
`define LSIR_STATUS_PERIOD_S 10
`define LSIR_IDLE_MIN_S      60
`define LSIR_IDLE_DEFAULT_S  3600
`define LSIR_CACHE_DEPTH     1024
`define LSIR_SLOTS           5

`define LSIR_OFF_CTRL        8'h00
`define LSIR_OFF_IDLE        8'h04
`define LSIR_OFF_STATUS      8'h08
`define LSIR_OFF_TOT_TX      8'h0c
`define LSIR_OFF_TOT_RX      8'h10
`define LSIR_OFF_SLOT_BASE   8'h20
`define LSIR_SLOT_STRIDE     8'h10

`define LSIR_CTRL_MODE_LSB   0
`define LSIR_CTRL_FLUSH_BIT  2
`define LSIR_CTRL_RESET      3'h0

`endif

// file: src/lsir_pkg.sv
// Types of the link status, idle restart and serial cache block.
// Used by the top module; constants live in lsir_params.svh.
package lsir_pkg;
   typedef enum logic [1:0] {
      LSIR_TCP_CLIENT = 2'b00,
      LSIR_TCP_SERVER = 2'b01,
      LSIR_UDP_CLIENT = 2'b10,
      LSIR_UDP_SERVER = 2'b11
   } lsir_mode_e;
   typedef logic [31:0] lsir_word_t;
endpackage : lsir_pkg

// file: src/lsir_tick.sv
// One-cycle enable pulse every PERIOD clock cycles.
// Assumes a single aclk domain with synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module lsir_tick #(
   parameter int unsigned PERIOD = 100
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      tick
);
   logic [31:0] count;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count <= 32'h0;
         tick  <= 1'b0;
      end
      else if (count == PERIOD[31:0] - 32'h1)
      begin
         count <= 32'h0;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 32'h1;
         tick  <= 1'b0;
      end
   end
endmodule : lsir_tick
`default_nettype wire

// file: src/lsir_fifo.sv
// Synchronous FIFO in flip-flops with valid/ready on both sides and a flush.
// Assumes one clock; flush wins over a push in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module lsir_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             flush,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready,
   output logic [AW:0]           level
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic             push;
   logic             pop;
   logic [AW:0]      next_level;

   assign push     = in_valid && in_ready;
   assign pop      = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_comb
   begin
      next_level = level;
      if (flush)
         next_level = '0;
      else if (push && !pop)
         next_level = level + 1'b1;
      else if (pop && !push)
         next_level = level - 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Flags are registered from the next level so they change in the same cycle as level.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         level     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end
      else
      begin
         level     <= next_level;
         in_ready  <= next_level < DEPTH[AW:0];
         out_valid <= next_level != '0;
      end
   end
endmodule : lsir_fifo
`default_nettype wire

// file: src/lsir_top.sv
// Link indicator, serial receive cache, idle restart and traffic counters.
// Assumes connection events and byte strobes come from logic on aclk.
//
// Overview of operation
// - TCP: indicator active when connected or in reset, else inactive.
// - UDP: indicator held active permanently.
// - Cache serial bytes while TCP is down.
// - Serial cache holds 1024 bytes.
// - Flush cache on connect only if enabled.
// - Restart after network idle exceeds set time.
// - Idle time 60 to 65535 s, default 3600.
// - Idle time below 60 stores zero, disabled.
// - TCP server: first five peers plus totals.
// - Status snapshot refreshed every 10 seconds.
// - UDP server: count bytes, never record addresses.
`include "lsir_params.svh"
`timescale 1ns/10ps
`default_nettype none
module lsir_top #(
   parameter int unsigned CLK_HZ     = `LSIR_CLK_HZ,
   parameter int unsigned SEC_CYCLES = CLK_HZ * `LSIR_SECOND_S,
   parameter bit          LINK_ACTIVE_LOW = 1'b1
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ser_rx_valid,
   input  wire logic [7:0]  ser_rx_data,
   output logic             ser_rx_ready,
   output logic             net_tx_valid,
   output logic [7:0]       net_tx_data,
   input  wire logic        net_tx_ready,
   input  wire logic        net_rx_byte,
   input  wire logic [2:0]  net_rx_slot,
   input  wire logic        tcp_conn_up,
   input  wire logic        peer_open,
   input  wire logic [2:0]  peer_slot,
   input  wire logic [31:0] peer_addr,
   output logic             link_pin,
   output logic             restart
);
   localparam int unsigned NS = `LSIR_SLOTS;

   // ---------------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------------
   logic [1:0]  mode;
   logic        flush_en;
   logic [15:0] idle_time;
   logic        is_tcp;

   assign is_tcp = !mode[1];

   // ---------------------------------------------------------------------
   // Serial cache
   // ---------------------------------------------------------------------
   logic        conn_q;
   logic        connect_edge;
   logic        fwd_en;
   logic        cache_flush;
   logic        fifo_valid;
   logic [10:0] cache_level;
   logic        tx_beat;

   assign connect_edge = tcp_conn_up && !conn_q;
   assign cache_flush  = connect_edge && is_tcp && flush_en;
   // Nothing leaves in the flush cycle, or the head byte would slip past the flush.
   assign fwd_en       = !is_tcp || (tcp_conn_up && !cache_flush);
   assign net_tx_valid = fifo_valid && fwd_en;
   assign tx_beat      = net_tx_valid && net_tx_ready;

   lsir_fifo #(
      .WIDTH (8),
      .DEPTH (`LSIR_CACHE_DEPTH)
   ) u_cache (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .flush     (cache_flush),
      .in_valid  (ser_rx_valid),
      .in_data   (ser_rx_data),
      .in_ready  (ser_rx_ready),
      .out_valid (fifo_valid),
      .out_data  (net_tx_data),
      .out_ready (net_tx_ready && fwd_en),
      .level     (cache_level)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         conn_q <= 1'b0;
      else
         conn_q <= tcp_conn_up;
   end

   // ---------------------------------------------------------------------
   // Link indicator
   // ---------------------------------------------------------------------
   logic link_active;

   assign link_active = is_tcp ? tcp_conn_up : 1'b1;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         link_pin <= !LINK_ACTIVE_LOW;
      else
         link_pin <= link_active ^ LINK_ACTIVE_LOW;
   end

   // ---------------------------------------------------------------------
   // Second tick, idle restart and status period
   // ---------------------------------------------------------------------
   logic        sec_tick;
   logic [16:0] idle_secs;
   logic [3:0]  snap_secs;
   logic        snap_tick;
   logic        net_activity;

   lsir_tick #(
      .PERIOD (SEC_CYCLES)
   ) u_sec (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (sec_tick)
   );

   assign net_activity = tx_beat || net_rx_byte;
   assign snap_tick    = sec_tick && snap_secs == 4'(`LSIR_STATUS_PERIOD_S - 1);

   // Activity wins over a tick so a byte in the tick cycle always counts.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || net_activity || restart)
         idle_secs <= 17'h0;
      else if (sec_tick && idle_secs != 17'h1ffff)
         idle_secs <= idle_secs + 17'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         restart <= 1'b0;
      else
         restart <= !restart && idle_time != 16'h0 && idle_secs > {1'b0, idle_time};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || snap_tick)
         snap_secs <= 4'h0;
      else if (sec_tick)
         snap_secs <= snap_secs + 4'h1;
   end

   // ---------------------------------------------------------------------
   // Traffic counters and published snapshot
   // ---------------------------------------------------------------------
   logic [31:0] tot_tx;
   logic [31:0] tot_rx;
   logic [31:0] pub_tot_tx;
   logic [31:0] pub_tot_rx;
   logic [31:0] slot_addr [NS];
   logic [31:0] slot_tx   [NS];
   logic [31:0] slot_rx   [NS];
   logic [31:0] pub_addr  [NS];
   logic [31:0] pub_tx    [NS];
   logic [31:0] pub_rx    [NS];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tot_tx <= 32'h0;
         tot_rx <= 32'h0;
      end
      else
      begin
         if (tx_beat)
            tot_tx <= tot_tx + 32'h1;
         if (net_rx_byte)
            tot_rx <= tot_rx + 32'h1;
      end
   end

   // Each connection is sent every cached byte, so one beat counts in all open slots.
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < NS; i++)
      begin
         if (!aresetn || mode != lsir_pkg::LSIR_TCP_SERVER)
         begin
            slot_addr[i] <= 32'h0;
            slot_tx[i]   <= 32'h0;
            slot_rx[i]   <= 32'h0;
         end
         else if (peer_open && peer_slot == 3'(i))
         begin
            slot_addr[i] <= peer_addr;
            slot_tx[i]   <= 32'h0;
            slot_rx[i]   <= 32'h0;
         end
         else
         begin
            if (tx_beat && slot_addr[i] != 32'h0)
               slot_tx[i] <= slot_tx[i] + 32'h1;
            if (net_rx_byte && net_rx_slot == 3'(i))
               slot_rx[i] <= slot_rx[i] + 32'h1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pub_tot_tx <= 32'h0;
         pub_tot_rx <= 32'h0;
         for (int i = 0; i < NS; i++)
         begin
            pub_addr[i] <= 32'h0;
            pub_tx[i]   <= 32'h0;
            pub_rx[i]   <= 32'h0;
         end
      end
      else if (snap_tick)
      begin
         pub_tot_tx <= tot_tx;
         pub_tot_rx <= tot_rx;
         for (int i = 0; i < NS; i++)
         begin
            pub_addr[i] <= slot_addr[i];
            pub_tx[i]   <= slot_tx[i];
            pub_rx[i]   <= slot_rx[i];
         end
      end
   end

   // ---------------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------------
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic [31:0] merged;

   function automatic logic [31:0] lsir_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[8*b +: 8] = new_v[8*b +: 8];
      return r;
   endfunction : lsir_merge

   function automatic logic lsir_is_slot(input logic [7:0] a, input int unsigned i,
                                         input logic [7:0] field);
      return a == 8'(`LSIR_OFF_SLOT_BASE + i * `LSIR_SLOT_STRIDE) + field;
   endfunction : lsir_is_slot

   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_addr       <= 8'h0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
      end
      else if (do_write)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         else if (!aw_held)
            s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         else if (!w_held)
            s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr == `LSIR_OFF_CTRL || aw_addr == `LSIR_OFF_IDLE) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   assign merged = lsir_merge({16'h0, idle_time}, w_data, w_strb);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {flush_en, mode} <= `LSIR_CTRL_RESET;
         idle_time <= 16'(`LSIR_IDLE_DEFAULT_S);
      end
      else if (do_write && aw_addr == `LSIR_OFF_CTRL)
      begin
         if (w_strb[0])
         begin
            mode     <= w_data[`LSIR_CTRL_MODE_LSB +: 2];
            flush_en <= w_data[`LSIR_CTRL_FLUSH_BIT];
         end
      end
      else if (do_write && aw_addr == `LSIR_OFF_IDLE)
         idle_time <= merged[15:0] < 16'(`LSIR_IDLE_MIN_S) ? 16'h0 : merged[15:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= 2'b00;
         case (s_axi_araddr)
            `LSIR_OFF_CTRL:   s_axi_rdata <= {29'h0, flush_en, mode};
            `LSIR_OFF_IDLE:   s_axi_rdata <= {16'h0, idle_time};
            `LSIR_OFF_STATUS: s_axi_rdata <= {19'h0, cache_level, link_pin, tcp_conn_up};
            `LSIR_OFF_TOT_TX: s_axi_rdata <= pub_tot_tx;
            `LSIR_OFF_TOT_RX: s_axi_rdata <= pub_tot_rx;
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'b10;
               for (int i = 0; i < NS; i++)
               begin
                  if (lsir_is_slot(s_axi_araddr, i, 8'h0))
                  begin
                     s_axi_rdata <= pub_addr[i];
                     s_axi_rresp <= 2'b00;
                  end
                  if (lsir_is_slot(s_axi_araddr, i, 8'h4))
                  begin
                     s_axi_rdata <= pub_tx[i];
                     s_axi_rresp <= 2'b00;
                  end
                  if (lsir_is_slot(s_axi_araddr, i, 8'h8))
                  begin
                     s_axi_rdata <= pub_rx[i];
                     s_axi_rresp <= 2'b00;
                  end
               end
            end
         endcase
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
      else
         s_axi_arready <= 1'b1;
   end

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   a_link_tcp_level: assert property (@(posedge aclk) disable iff (!aresetn)
      is_tcp && $stable(mode) |=> link_pin == ($past(tcp_conn_up) ^ LINK_ACTIVE_LOW))
      else $error("link pin does not follow tcp connection");

   a_link_udp_held: assert property (@(posedge aclk) disable iff (!aresetn)
      !is_tcp [*2] |-> link_pin == !LINK_ACTIVE_LOW)
      else $error("link pin not active in udp mode");

   a_cache_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      is_tcp && !tcp_conn_up |-> !tx_beat)
      else $error("cached byte forwarded without connection");

   a_cache_flush: assert property (@(posedge aclk) disable iff (!aresetn)
      connect_edge && is_tcp && !flush_en && cache_level != 11'h0 |=> cache_level != 11'h0)
      else $error("cache emptied on connect with flush disabled");

   a_flush_no_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
      cache_flush |-> !tx_beat)
      else $error("byte forwarded in flush cycle");

   a_idle_restart: assert property (@(posedge aclk) disable iff (!aresetn)
      restart |-> $past(idle_secs) > {1'b0, $past(idle_time)} && $past(idle_time) != 16'h0)
      else $error("restart without idle timeout");

   a_idle_min: assert property (@(posedge aclk) disable iff (!aresetn)
      idle_time == 16'h0 || idle_time >= 16'(`LSIR_IDLE_MIN_S))
      else $error("idle time below minimum stored");

   a_idle_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      net_activity |=> idle_secs == 17'h0 ##1 idle_secs <= 17'h1)
      else $error("idle count not cleared by traffic");

   a_snap_period: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(pub_tot_tx) |-> $past(snap_tick))
      else $error("snapshot changed outside refresh");

   a_udp_noaddr: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == lsir_pkg::LSIR_UDP_SERVER |=> slot_addr[0] == 32'h0 && slot_addr[4] == 32'h0)
      else $error("peer address recorded in udp server");
endmodule : lsir_top
`default_nettype wire

// file: sim/lsir_partner.sv
// Far-side model: the serial device feeding the cache and the network sink.
// Assumes one aclk; the bench fills src_q and reads got_q by hierarchy.
`timescale 1ns/10ps
`default_nettype none
module lsir_partner (
   input  wire logic       aclk,
   input  wire logic       slow,
   output logic            ser_rx_valid,
   output logic [7:0]      ser_rx_data,
   input  wire logic       ser_rx_ready,
   input  wire logic       net_tx_valid,
   input  wire logic [7:0] net_tx_data,
   output logic            net_tx_ready
);
   logic [7:0] src_q[$];
   logic [7:0] got_q[$];
   logic [1:0] cyc;
   initial
   begin
      ser_rx_valid = 1'b0;
      ser_rx_data  = 8'h00;
      net_tx_ready = 1'b0;
      cyc          = 2'h0;
   end
   // ----------------------------------------------------------------
   // Streams
   // ----------------------------------------------------------------
   // Idle data toggles every cycle, so a stale byte never looks settled.
   always @(posedge aclk)
   begin
      cyc <= cyc + 2'h1;
      if (ser_rx_valid && ser_rx_ready)
         void'(src_q.pop_front());
      if (src_q.size() > 0)
      begin
         ser_rx_valid <= 1'b1;
         ser_rx_data  <= src_q[0];
      end
      else
      begin
         ser_rx_valid <= 1'b0;
         ser_rx_data  <= ~ser_rx_data;
      end
      if (net_tx_valid && net_tx_ready)
         got_q.push_back(net_tx_data);
      net_tx_ready <= !slow || (cyc == 2'h0);
   end
endmodule : lsir_partner
`default_nettype wire

// file: sim/link_status_idle_restart_tb.sv
// Self-checking bench for lsir_top with a shortened second.
// Assumes lsir_partner as far side and registers at the documented offsets.
`timescale 1ns/10ps
`default_nettype none
module link_status_idle_restart_tb;
   localparam int unsigned SEC = 20;
   typedef struct {
      logic [7:0]  a;
      logic [31:0] d;
      logic [1:0]  b;
      logic [31:0] q;
      logic [1:0]  r;
   } lsir_row_s;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
   logic        awready, wready, bvalid, arready, rvalid, link_pin, restart;
   logic        svalid, sready, tvalid, tready, net_rx_byte, tcp_conn_up, peer_open;
   logic [7:0]  awaddr, araddr, sdata, tdata;
   logic [31:0] wdata, rdata, peer_addr, lv;
   logic [1:0]  bresp, rresp, lr;
   logic [2:0]  net_rx_slot, peer_slot;
   int          err_total, tests_run, n_rst, n0, cyc, t_rst, t0, k;
   lsir_row_s   rows [5] = '{
      '{8'h04, 32'd60, 2'b00, 32'd60, 2'b00},
      '{8'h04, 32'd65535, 2'b00, 32'h0000ffff, 2'b00},
      '{8'h00, 32'h5, 2'b00, 32'h5, 2'b00},
      '{8'h1c, 32'h1, 2'b10, 32'h0, 2'b10},
      '{8'h04, 32'h0001003b, 2'b00, 32'h0, 2'b00}};

   lsir_top #(.SEC_CYCLES(SEC)) i_lsir_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ser_rx_valid(svalid),
      .ser_rx_data(sdata), .ser_rx_ready(sready), .net_tx_valid(tvalid),
      .net_tx_data(tdata), .net_tx_ready(tready), .net_rx_byte(net_rx_byte),
      .net_rx_slot(net_rx_slot), .tcp_conn_up(tcp_conn_up), .peer_open(peer_open),
      .peer_slot(peer_slot), .peer_addr(peer_addr), .link_pin(link_pin),
      .restart(restart));
   lsir_partner i_lsir_partner (.aclk(aclk), .slow(slow), .ser_rx_valid(svalid),
      .ser_rx_data(sdata), .ser_rx_ready(sready), .net_tx_valid(tvalid),
      .net_tx_data(tdata), .net_tx_ready(tready));

   // ----------------------------------------------------------------
   // Clock, monitors and tasks
   // ----------------------------------------------------------------
   initial aclk = 1'b0;
   always #5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (restart === 1'b1)
      begin
         n_rst <= n_rst + 1;
         t_rst <= cyc;
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!awready);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!wready);
            wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (!bvalid);
      lr = bresp;
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      lv = rdata;
      lr = rresp;
      rready <= 1'b0;
   endtask : axr

   // Announces a peer in slot s, then n network bytes from it (n at least 1).
   task automatic ev(input logic [2:0] s, input logic [31:0] a, input int n);
      @(posedge aclk);
      peer_slot   <= s;
      peer_addr   <= a;
      peer_open   <= 1'b1;
      net_rx_slot <= s;
      @(posedge aclk);
      peer_open   <= 1'b0;
      net_rx_byte <= 1'b1;
      repeat (n) @(posedge aclk);
      net_rx_byte <= 1'b0;
   endtask : ev

   task automatic test_done;
      if (err_total == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   initial
   begin
      repeat (20000) @(posedge aclk);
      err_total++;
      test_done();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
      {net_rx_byte, tcp_conn_up, peer_open, net_rx_slot, peer_slot} = '0;
      {awaddr, araddr, wdata, peer_addr} = '0;
      {err_total, tests_run, n_rst, cyc, t_rst} = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("link_pin after reset", link_pin, 32'h1);
      axr(8'h04);
      chk("idle default", lv, 32'd3600);
      foreach (rows[i])
      begin
         axw(rows[i].a, rows[i].d);
         chk("bresp", lr, rows[i].b);
         axr(rows[i].a);
         chk("rdata", lv, rows[i].q);
         chk("rresp", lr, rows[i].r);
      end
      axw(8'h00, 32'h1);
      ev(3'h0, 32'h0a000001, 3);
      ev(3'h5, 32'h0a000009, 1);
      repeat (11 * SEC + 10) @(posedge aclk);
      axr(8'h20);
      chk("slot0 addr", lv, 32'h0a000001);
      axr(8'h28);
      chk("slot0 rx", lv, 32'd3);
      axw(8'h00, 32'h3);
      ev(3'h1, 32'h0a000002, 2);
      repeat (11 * SEC + 10) @(posedge aclk);
      axr(8'h30);
      chk("udp slot1 addr", lv, 32'h0);
      axr(8'h10);
      chk("total rx", lv, 32'd6);
      for (int m = 0; m < 8; m++)
      begin
         axw(8'h00, m / 2);
         tcp_conn_up <= m[0];
         repeat (3) @(posedge aclk);
         chk("link_pin", link_pin, (m > 3) ? 32'h0 : {31'h0, !m[0]});
      end
      tcp_conn_up <= 1'b0;
      axw(8'h00, 32'h0);
      slow <= 1'b1;
      for (int i = 0; i < 1030; i++)
         i_lsir_partner.src_q.push_back(i[7:0]);
      repeat (1100) @(posedge aclk);
      chk("ser_rx_ready full", sready, 32'h0);
      chk("nothing forwarded", i_lsir_partner.got_q.size(), 32'h0);
      chk("bytes refused", i_lsir_partner.src_q.size(), 32'd6);
      axr(8'h08);
      chk("cache level", {21'h0, lv[12:2]}, 32'd1024);
      tcp_conn_up <= 1'b1;
      for (k = 0; k < 6000 && i_lsir_partner.got_q.size() < 1030; k++)
         @(posedge aclk);
      for (int i = 0; i < 1030; i++)
         chk("kept byte", i_lsir_partner.got_q[i], i[7:0]);
      tcp_conn_up <= 1'b0;
      slow <= 1'b0;
      axw(8'h00, 32'h4);
      for (int i = 0; i < 5; i++)
         i_lsir_partner.src_q.push_back(8'ha0);
      repeat (20) @(posedge aclk);
      tcp_conn_up <= 1'b1;
      repeat (20) @(posedge aclk);
      chk("flushed bytes", i_lsir_partner.got_q.size(), 32'd1030);
      axr(8'h08);
      chk("level after flush", {21'h0, lv[12:2]}, 32'h0);
      axw(8'h04, 32'd60);
      n0 = n_rst;
      ev(3'h0, 32'h0, 1);
      repeat (40 * SEC) @(posedge aclk);
      ev(3'h0, 32'h0, 1);
      t0 = cyc;
      for (k = 0; k < 1400 && n_rst == n0; k++)
         @(posedge aclk);
      chk("one restart", n_rst, n0 + 1);
      chk("idle span", (t_rst - t0 > 60 * SEC) && (t_rst - t0 <= 61 * SEC + 4), 32'h1);
      axw(8'h04, 32'd59);
      n0 = n_rst;
      repeat (70 * SEC) @(posedge aclk);
      chk("disabled restart", n_rst, n0);
      axr(8'h0c);
      chk("total tx", lv, 32'd1030);
      test_done();
   end
endmodule : link_status_idle_restart_tb
`default_nettype wire
